// ===== rtm_receiver.sv
// Receive-side message interpreter with write data path and AHB-Lite slave
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "rtm_defs.svh"
// Functional notes
// [R1] Message parity starts all ones, toggles per one bit, ends zero
// [R2] Poll: read if requested, else reject (normal) or ack (wait)
// [R3] In wait condition a later read request sends read unprompted
// [R4] Wait cleared by reset, manual release or a new message
// [R5] Attended alert lights lamp and alarm, replies acknowledge
// [R6] Send key clears alert, inserts end code one, resets marker
// [R7] Unattended alert raises read request, ack, next read is one word
// [R8] Write code stores following data words at the entry marker
// [R9] Assembly register, three buffer registers, disassembly register
// [R10] One stage step per half symbol, never into an occupied stage
// [R11] Full disassembly register blocks chain until memory takes it
// [R12] Word parity failure becomes the parity error symbol
// [R13] Escape stays out; next word is function code and is buffered
// [R14] Entry marker steps once per word written to memory
// [R15] External code set swaps codes 00 and 20
// [R16] Internal code set remaps groups and codes 00 and 12
// [R17] Codes without a conversion pass unchanged
// [R18] End of message sets sequence five, stops entry, chain drains
// [R19] Parity word sets sequence six and ends reception with reply
// [R20] Write reply: ack, reject when busy, error when errors seen
// [R21] Reset and clear writes skip seven syncs, outside data and parity
// [R22] Clear write clears memory and resets marker; reset write resets
// [R23] Data arrives in the code set selected at the controller
// [R24] Diagnostic write is a distinct message type
// [R25] Every received word is checked for odd parity; the code does not check the parity bit of the closing message parity word
// [R26] Sync code is looked for as each bit shifts in
module rtm_receiver
  import rtm_pkg::*;
#(
  parameter logic [6:0] ALERT_CODE   = 7'h07,
  parameter logic [6:0] END_ONE_CODE = 7'h45
)
(
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        rxClk,
  input  wire logic        rxData,
  input  wire logic        sendKey,
  input  wire logic        siteBusy,
  input  wire logic        entryHit,
  output rtm_mem_t         memPort,
  output rtm_reply_t       replyPort,
  output rtm_func_t        funcPort,
  output logic             alertOn
);
  logic [2:0]  clkSync_reg;
  logic [2:0]  datSync_reg;
  logic        clkLvl_reg;
  logic        datLvl_reg;
  rtm_state_t  state_reg;
  rtm_state_t  stateNext;
  rtm_kind_t   kind_reg;
  logic [2:0]  seq_reg;
  logic [2:0]  seqNext;
  logic [2:0]  bitCnt_reg;
  logic [2:0]  skipCnt_reg;
  logic [7:0]  asm_reg;
  logic [6:0]  msgPar_reg;
  logic [7:0]  halfCnt_reg;
  logic        busy_reg;
  logic        err_reg;
  logic        escPend_reg;
  logic        waitCond_reg;
  logic        readReq_reg;
  logic        e1Only_reg;
  logic        e1Insert_reg;
  logic        resetPend_reg;
  logic        overrun_reg;
  logic [4:0]  ctrl_reg;
  logic [7:0]  lastReply_reg;
  logic        wrPend_reg;
  logic [7:0]  wrAddr_reg;
  logic [`RTM_STAGES-1:0] stageFull_reg;
  logic [6:0]  stageData_reg [0:`RTM_STAGES-1];
  logic [`RTM_STAGES-1:0] move;
  logic [6:0]  dataNext [0:`RTM_STAGES-1];
  logic        abortErr;
  logic        finish;
  logic        ctrlDone;
  logic        rSend;
  logic [6:0]  rCode;
  logic        readUse;
  logic        readSet;
  logic        waitSet;
  logic        waitClr;
  logic        lampSet;
  logic        e1Set;

  // Link inputs: three flops, a change counts once second and third agree
  wire clkAgree = clkSync_reg[1] == clkSync_reg[2];
  wire datAgree = datSync_reg[1] == datSync_reg[2];
  wire bitFall  = clkAgree & ~clkSync_reg[2] & clkLvl_reg;
  wire bitIn    = datAgree ? datSync_reg[2] : datLvl_reg;
  wire [7:0] asmNext = {bitIn, asm_reg[7:1]};
  wire [6:0] code    = asmNext[6:0];
  wire parOk         = ^asmNext; // [R25]
  wire framed        = state_reg != RTM_HUNT;
  wire wordDone      = bitFall & framed & (bitCnt_reg == `RTM_BIT_LAST);
  wire isSync        = parOk & (code == `RTM_CODE_SYNC);
  wire isSoh         = parOk & (code == `RTM_CODE_SOH);
  wire isEtx         = parOk & (code == `RTM_CODE_ETX);
  // Sync search runs on every shifted bit, not on word boundaries
  wire syncHit = bitFall & ~framed & (asmNext[6:0] == `RTM_CODE_SYNC)
                 & parOk; // [R26]
  wire headSoh = wordDone & (state_reg == RTM_HEAD)
                 & (seq_reg == `RTM_SEQ_SYNC) & isSoh;

  wire attended = ctrl_reg[`RTM_CTRL_ATTEND];
  wire pollWait = ctrl_reg[`RTM_CTRL_WAIT];
  wire extCode  = ctrl_reg[`RTM_CTRL_EXT];
  wire errEn    = ctrl_reg[`RTM_CTRL_ERREN];

  wire isRw   = code == `RTM_CODE_RWRITE;
  wire isCw   = code == `RTM_CODE_CWRITE;
  wire isDiag = code == `RTM_CODE_DIAG; // [R24]
  wire isWr   = code == `RTM_CODE_WRITE;
  wire rtm_kind_t newKind = (code == `RTM_CODE_POLL) ? RTM_K_POLL :
                            (code == ALERT_CODE) ? RTM_K_ALERT :
                            isDiag ? RTM_K_DIAG :
                            (isWr | isRw | isCw) ? RTM_K_WRITE : RTM_K_BAD;
  wire diagMsg = kind_reg == RTM_K_DIAG;

  always_comb
  begin
    stateNext = state_reg;
    seqNext   = seq_reg;
    abortErr  = 1'b0;
    finish    = 1'b0;
    ctrlDone  = 1'b0;
    case (state_reg)
      RTM_HUNT:
        if (syncHit)
          stateNext = RTM_SECOND;
      RTM_SECOND:
        if (wordDone)
          stateNext = isSync ? RTM_HEAD : RTM_HUNT;
      RTM_HEAD:
        if (wordDone)
        begin
          if (seq_reg == `RTM_SEQ_SYNC)
          begin
            if (isSoh)
              seqNext = `RTM_SEQ_SOH;
            else if (!isSync)
              stateNext = RTM_HUNT;
          end
          else if (!parOk)
          begin
            stateNext = RTM_HUNT;
            abortErr  = 1'b1;
          end
          else if (seq_reg == `RTM_SEQ_STA)
          begin
            seqNext  = `RTM_SEQ_CTRL;
            ctrlDone = 1'b1;
            // Syncs after a reset, clear or diagnostic write code are skipped [R21]
            stateNext = (isRw | isCw | isDiag) ? RTM_SKIP :
                        isWr ? RTM_DATA : RTM_TAIL; // [R8]
          end
          else
            seqNext = seq_reg + 3'h1;
        end
      RTM_SKIP:
        if (wordDone & (!isSync | (skipCnt_reg == `RTM_SKIP_LAST)))
          stateNext = RTM_DATA; // [R21]
      RTM_DATA:
        if (wordDone & isEtx)
        begin
          seqNext   = `RTM_SEQ_ETX; // [R18]
          stateNext = RTM_TAIL;
        end
      RTM_TAIL:
        if (wordDone)
        begin
          if (seq_reg == `RTM_SEQ_ETX)
          begin
            seqNext   = `RTM_SEQ_PAR; // [R19]
            stateNext = RTM_HUNT;
            finish    = 1'b1;
          end
          else if (isEtx)
            seqNext = `RTM_SEQ_ETX; // [R18]
          else
          begin
            stateNext = RTM_HUNT;
            abortErr  = 1'b1;
          end
        end
      default:
        stateNext = RTM_HUNT;
    endcase
  end

  // Syncs before the header and in the skip window stay out of parity
  wire parUpd = wordDone & ((state_reg == RTM_HEAD
                & seq_reg != `RTM_SEQ_SYNC) | state_reg == RTM_DATA
                | state_reg == RTM_TAIL);
  wire [6:0] msgParNext = headSoh ? (`RTM_MSGPAR_INIT ^ code)
                                  : (msgPar_reg ^ code); // [R1]
  wire msgBad = msgParNext != 7'h00; // [R1]

  wire skipBad  = wordDone & (state_reg == RTM_SKIP) & !isSync;
  wire dataWord = wordDone & (state_reg == RTM_DATA) & ~isEtx;
  wire [6:0] escCode = extCode ? `RTM_ESC_EXT : `RTM_ESC_INT;
  wire escStart   = dataWord & parOk & ~escPend_reg
                    & (code == escCode); // [R13]
  wire wordAccept = dataWord & ~escStart;
  wire dataErr    = (dataWord & !parOk) | skipBad;
  wire anyErr     = (err_reg | dataErr | msgBad
                    | (kind_reg == RTM_K_BAD)) & ~diagMsg;

  function automatic logic [6:0] convBcd(input logic [6:0] c,
                                         input logic ext);
    logic [5:0] v;
    v = c[5:0]; // [R17]
    if (ext)
    begin
      if (c[5:0] == `RTM_BCD_00)
        v = `RTM_BCD_20; // [R15]
      else if (c[5:0] == `RTM_BCD_20)
        v = `RTM_BCD_00; // [R15]
    end
    else if (c[5:0] == `RTM_BCD_00)
      v = `RTM_BCD_12; // [R16]
    else if (c[5:0] == `RTM_BCD_12)
      v = `RTM_BCD_20; // [R16]
    else if (c[5:3] == `RTM_GRP_2)
      v = {`RTM_GRP_6, c[2:0]}; // [R16]
    else if (c[5:3] == `RTM_GRP_6 && c[5:0] != `RTM_BCD_60)
      v = {`RTM_GRP_2, c[2:0]}; // [R16]
    else if (c[5:3] == `RTM_GRP_7)
      v = {`RTM_GRP_3, c[2:0]}; // [R16]
    return {c[6], v};
  endfunction

  // Data word enters stage 0 only in the data state, so ETX stops entry
  wire [6:0] wordValue = !parOk ? `RTM_PAR_SYMBOL : // [R12]
                         escPend_reg ? code : // [R13]
                         convBcd(code, extCode); // [R23]
  wire wordLoad  = wordAccept & ~stageFull_reg[0];
  wire e1Load    = e1Insert_reg & ~stageFull_reg[0] & ~wordAccept; // [R6]
  wire [6:0] loadData = wordAccept ? wordValue : END_ONE_CODE;
  wire tick  = halfCnt_reg == 8'(`RTM_HALF_SYM_CYC - 1);
  wire drain = stageFull_reg[`RTM_STAGES-1] & entryHit; // [R11]
  wire [`RTM_STAGES-1:0] leave = {drain, move[`RTM_STAGES-1:1]};
  wire [`RTM_STAGES-1:0] fullNext = (stageFull_reg & ~leave) | move;
  wire markerFire = resetPend_reg & ~|stageFull_reg & ~e1Insert_reg;

  // Chain: stage 0 assembly hold, 1..3 buffers, 4 disassembly [R9]
  genvar g;
  for (g = 0; g < `RTM_STAGES; g++)
  begin : gStage
    if (g == 0)
    begin : gFirst
      assign move[g]     = wordLoad | e1Load;
      assign dataNext[g] = move[g] ? loadData : stageData_reg[g];
    end
    else
    begin : gRest
      // Steps only on the half-symbol tick into an empty stage [R10]
      assign move[g] = tick & stageFull_reg[g-1] & ~stageFull_reg[g];
      assign dataNext[g] = move[g] ? stageData_reg[g-1] : stageData_reg[g];
    end
  end

  always_ff @(posedge mclk)
  begin
    stageData_reg <= dataNext;
    if (!reset_n)
      stageFull_reg <= '0;
    else
      stageFull_reg <= fullNext;
  end

  // Reply selection at end of reception, abort, or wait-mode read
  always_comb
  begin
    rSend   = 1'b0;
    rCode   = `RTM_CODE_ACK;
    readUse = 1'b0;
    readSet = 1'b0;
    waitSet = 1'b0;
    waitClr = 1'b0;
    lampSet = 1'b0;
    e1Set   = 1'b0;
    if (finish)
    begin
      rSend = 1'b1;
      if (anyErr)
      begin
        rCode = `RTM_CODE_ERROR; // [R20]
        rSend = errEn;
      end
      else
        case (kind_reg)
          RTM_K_POLL:
            if (readReq_reg)
            begin
              rCode   = `RTM_CODE_READ; // [R2]
              readUse = 1'b1;
            end
            else if (pollWait)
              waitSet = 1'b1; // [R2]
            else
              rCode = `RTM_CODE_REJECT; // [R2]
          RTM_K_ALERT:
            if (attended)
              lampSet = 1'b1; // [R5]
            else
            begin
              readSet = 1'b1; // [R7]
              e1Set   = 1'b1;
            end
          RTM_K_WRITE:
            if (busy_reg)
              rCode = `RTM_CODE_REJECT; // [R20]
          default:
            rCode = busy_reg ? `RTM_CODE_REJECT : `RTM_CODE_READ;
        endcase
    end
    else if (abortErr)
    begin
      rCode = `RTM_CODE_ERROR;
      rSend = errEn;
    end
    else if (state_reg == RTM_HUNT && waitCond_reg && readReq_reg)
    begin
      rCode   = `RTM_CODE_READ; // [R3]
      rSend   = 1'b1;
      readUse = 1'b1;
      waitClr = 1'b1;
    end
  end

  // Bus side: zero wait states, read data captured at the address phase
  wire addrPhase = hsel & hready & (htrans == `RTM_HTRANS_NSEQ)
                   & (hsize == `RTM_HSIZE_WORD);
  wire hiZero    = haddr[31:8] == 24'h0;
  wire ctrlWrite = wrPend_reg & (wrAddr_reg == `RTM_ADDR_CTRL);
  wire manRelease = ctrlWrite & hwdata[`RTM_CTRL_RELEASE];
  wire [31:0] statusWord = {11'h000, stageFull_reg, 1'b0, msgPar_reg,
                            1'b0, seq_reg, overrun_reg, alertOn,
                            readReq_reg, waitCond_reg};
  wire [31:0] rdValue =
    (hiZero & haddr[7:0] == `RTM_ADDR_CTRL) ? {27'h0, ctrl_reg} :
    (hiZero & haddr[7:0] == `RTM_ADDR_STATUS) ? statusWord :
    (hiZero & haddr[7:0] == `RTM_ADDR_REPLY) ? {24'h0, lastReply_reg} :
    32'h0;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0;
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      ctrl_reg   <= 5'h00;
    end
    else
    begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= (addrPhase & ~hwrite) ? rdValue : 32'h0;
      wrPend_reg <= addrPhase & hwrite & hiZero;
      wrAddr_reg <= haddr[7:0];
      if (ctrlWrite)
        ctrl_reg <= hwdata[4:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      clkSync_reg <= 3'h0;
      datSync_reg <= 3'h0;
      clkLvl_reg  <= 1'b0;
      datLvl_reg  <= 1'b0;
      asm_reg     <= 8'h00;
      bitCnt_reg  <= 3'h0;
      halfCnt_reg <= 8'h00;
    end
    else
    begin
      clkSync_reg <= {clkSync_reg[1:0], rxClk};
      datSync_reg <= {datSync_reg[1:0], rxData};
      clkLvl_reg  <= clkAgree ? clkSync_reg[2] : clkLvl_reg;
      datLvl_reg  <= datAgree ? datSync_reg[2] : datLvl_reg;
      asm_reg     <= bitFall ? asmNext : asm_reg;
      bitCnt_reg  <= (syncHit | ~framed) ? 3'h0 :
                     bitFall ? bitCnt_reg + 3'h1 : bitCnt_reg;
      halfCnt_reg <= tick ? 8'h00 : halfCnt_reg + 8'h01;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg   <= RTM_HUNT;
      seq_reg     <= `RTM_SEQ_SYNC;
      kind_reg    <= RTM_K_BAD;
      skipCnt_reg <= 3'h0;
      msgPar_reg  <= `RTM_MSGPAR_INIT;
      busy_reg    <= 1'b0;
      err_reg     <= 1'b0;
      escPend_reg <= 1'b0;
    end
    else
    begin
      state_reg   <= stateNext;
      seq_reg     <= syncHit ? `RTM_SEQ_SYNC : seqNext;
      kind_reg    <= ctrlDone ? newKind : kind_reg;
      busy_reg    <= ctrlDone ? siteBusy : busy_reg;
      skipCnt_reg <= ctrlDone ? 3'h0 :
                     (wordDone & isSync) ? skipCnt_reg + 3'h1 : skipCnt_reg;
      msgPar_reg  <= (headSoh | parUpd) ? msgParNext : msgPar_reg;
      err_reg     <= headSoh ? 1'b0 : err_reg | dataErr;
      escPend_reg <= headSoh ? 1'b0 : escStart | (escPend_reg & ~dataWord);
    end
  end

  // Flags set by events win over a clear in the same cycle
  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      waitCond_reg  <= 1'b0;
      readReq_reg   <= 1'b0;
      e1Only_reg    <= 1'b0;
      e1Insert_reg  <= 1'b0;
      resetPend_reg <= 1'b0;
      overrun_reg   <= 1'b0;
      alertOn       <= 1'b0;
      lastReply_reg <= 8'h00;
    end
    else
    begin
      waitCond_reg  <= waitSet | (waitCond_reg
                       & ~(manRelease | headSoh | waitClr)); // [R4]
      readReq_reg   <= readSet | sendKey | (readReq_reg & ~readUse);
      e1Only_reg    <= e1Set | (e1Only_reg & ~readUse); // [R7]
      e1Insert_reg  <= (sendKey & alertOn) | (e1Insert_reg & ~e1Load);
      resetPend_reg <= e1Load | (resetPend_reg & ~markerFire); // [R6]
      overrun_reg   <= (wordAccept & stageFull_reg[0]) | overrun_reg;
      alertOn       <= lampSet | (alertOn & ~sendKey); // [R5]
      lastReply_reg <= rSend ? {readUse & e1Only_reg, rCode} : lastReply_reg;
    end
  end

  wire ctrlClear = ctrlDone & isCw & ~siteBusy;
  wire ctrlReset = ctrlDone & (isCw | isRw | isDiag) & ~siteBusy;

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      memPort   <= '0;
      replyPort <= '0;
      funcPort  <= '0;
    end
    else
    begin
      memPort.write       <= drain;
      memPort.step        <= drain; // [R14]
      memPort.data        <= stageData_reg[`RTM_STAGES-1];
      memPort.clear       <= ctrlClear; // [R22]
      memPort.markerReset <= ctrlReset | markerFire; // [R22] [R6]
      memPort.toLine      <= ctrl_reg[`RTM_CTRL_LINE];
      replyPort.valid     <= rSend;
      replyPort.oneWord   <= readUse & e1Only_reg;
      replyPort.code      <= rCode;
      funcPort.strobe     <= wordAccept & escPend_reg & parOk; // [R13]
      funcPort.code       <= code;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  a_parity_init: assert property ( // [R1]
    headSoh |=> msgPar_reg == (`RTM_MSGPAR_INIT ^ `RTM_CODE_SOH))
    else $error("Message parity not started from all ones");
  a_poll_read: assert property ( // [R2]
    (finish && kind_reg == RTM_K_POLL && !anyErr && readReq_reg)
    |=> replyPort.valid && replyPort.code == `RTM_CODE_READ)
    else $error("Poll with read request did not answer read");
  a_poll_reject: assert property ( // [R2]
    (finish && kind_reg == RTM_K_POLL && !anyErr && !readReq_reg
     && !pollWait) |=> replyPort.code == `RTM_CODE_REJECT)
    else $error("Normal poll without request did not reject");
  a_wait_read: assert property ( // [R3]
    (state_reg == RTM_HUNT && waitCond_reg && readReq_reg)
    |=> replyPort.valid && replyPort.code == `RTM_CODE_READ
        && !waitCond_reg)
    else $error("Wait condition did not send read");
  a_wait_release: assert property ( // [R4]
    (manRelease && !waitSet) |=> !waitCond_reg)
    else $error("Manual release left wait condition set");
  a_alert_lamp: assert property ( // [R5]
    (finish && kind_reg == RTM_K_ALERT && !anyErr && attended)
    |=> alertOn && replyPort.code == `RTM_CODE_ACK)
    else $error("Attended alert did not light lamp");
  a_chain_hold: assert property ( // [R11]
    (stageFull_reg[`RTM_STAGES-1] && !entryHit)
    |=> stageFull_reg[`RTM_STAGES-1]
        && $stable(stageData_reg[`RTM_STAGES-1]))
    else $error("Disassembly register lost its word");
  a_parity_sub: assert property ( // [R12]
    (wordLoad && !parOk) |=> stageData_reg[0] == `RTM_PAR_SYMBOL)
    else $error("Parity error symbol not substituted");
  a_mem_write: assert property ( // [R14]
    drain |=> memPort.write && memPort.step
              && memPort.data == $past(stageData_reg[`RTM_STAGES-1]))
    else $error("Memory write or marker step missing");
  a_etx_stop: assert property ( // [R18]
    (seq_reg == `RTM_SEQ_ETX) |-> !wordLoad)
    else $error("Word entered chain after end of message");

  c_poll_reply: cover property (finish && kind_reg == RTM_K_POLL);
  c_chain_full: cover property (&stageFull_reg);
  c_auto_read: cover property (waitClr);
  c_write_ack: cover property (finish && kind_reg == RTM_K_WRITE && !anyErr);
endmodule

// ===== rtm_defs.svh
// Constants for the remote terminal message receiver
`ifndef RTM_DEFS_SVH
`define RTM_DEFS_SVH
`define RTM_CODE_SYNC    7'h16
`define RTM_CODE_SOH     7'h01
`define RTM_CODE_ETX     7'h03
`define RTM_CODE_POLL    7'h05
`define RTM_CODE_WRITE   7'h11
`define RTM_CODE_RWRITE  7'h0C
`define RTM_CODE_CWRITE  7'h12
`define RTM_CODE_DIAG    7'h10
`define RTM_CODE_ACK     7'h06
`define RTM_CODE_REJECT  7'h18
`define RTM_CODE_ERROR   7'h15
`define RTM_CODE_READ    7'h13
`define RTM_ESC_EXT      7'h3E
`define RTM_ESC_INT      7'h5E
`define RTM_PAR_SYMBOL   7'h3E
`define RTM_MSGPAR_INIT  7'h7F
`define RTM_SEQ_SYNC     3'h0
`define RTM_SEQ_SOH      3'h1
`define RTM_SEQ_STA      3'h3
`define RTM_SEQ_CTRL     3'h4
`define RTM_SEQ_ETX      3'h5
`define RTM_SEQ_PAR      3'h6
`define RTM_BIT_LAST     3'h7
`define RTM_SKIP_LAST    3'h6
`define RTM_STAGES       5
`define RTM_HALF_SYM_NS  8400
`define RTM_CLK_NS       50
`define RTM_HALF_SYM_CYC (`RTM_HALF_SYM_NS / `RTM_CLK_NS)
`define RTM_BCD_00       6'h00
`define RTM_BCD_12       6'h0A
`define RTM_BCD_20       6'h10
`define RTM_BCD_60       6'h30
`define RTM_GRP_2        3'h2
`define RTM_GRP_3        3'h3
`define RTM_GRP_6        3'h6
`define RTM_GRP_7        3'h7
`define RTM_ADDR_CTRL    8'h00
`define RTM_ADDR_STATUS  8'h04
`define RTM_ADDR_REPLY   8'h08
`define RTM_CTRL_ATTEND  0
`define RTM_CTRL_WAIT    1
`define RTM_CTRL_EXT     2
`define RTM_CTRL_ERREN   3
`define RTM_CTRL_LINE    4
`define RTM_CTRL_RELEASE 8
`define RTM_HTRANS_NSEQ  2'h2
`define RTM_HSIZE_WORD   3'h2
`endif

// ===== rtm_pkg.sv
// Types for the remote terminal message receiver
package rtm_pkg;
  typedef enum logic [5:0] {
    RTM_HUNT   = 6'b000001,
    RTM_SECOND = 6'b000010,
    RTM_HEAD   = 6'b000100,
    RTM_SKIP   = 6'b001000,
    RTM_DATA   = 6'b010000,
    RTM_TAIL   = 6'b100000
  } rtm_state_t;
  typedef enum logic [4:0] {
    RTM_K_POLL  = 5'b00001,
    RTM_K_ALERT = 5'b00010,
    RTM_K_WRITE = 5'b00100,
    RTM_K_DIAG  = 5'b01000,
    RTM_K_BAD   = 5'b10000
  } rtm_kind_t;
  typedef struct packed {
    logic       valid;
    logic       oneWord;
    logic [6:0] code;
  } rtm_reply_t;
  typedef struct packed {
    logic       write;
    logic       step;
    logic       clear;
    logic       markerReset;
    logic       toLine;
    logic [6:0] data;
  } rtm_mem_t;
  typedef struct packed {
    logic       strobe;
    logic [6:0] code;
  } rtm_func_t;
endpackage

// ===== rtm_source.sv
// Model of the remote data source on the synchronous modem link
`timescale 1ns/1ps
module rtm_source
(
  output logic rxClk = 1'b0,
  output logic rxData = 1'b1
);
  logic [6:0] dat[$];
  logic [6:0] mp;
  // Data moves a quarter period after the falling edge, never on it
  task automatic word(input logic [6:0] w, input logic bad);
    logic [7:0] b;
    b = {~^w ^ bad, w};
    for (int i = 0; i < 8; i++)
    begin
      rxData = b[i];
      #100 rxClk = 1'b1;
      #200 rxClk = 1'b0;
      #100;
    end
  endtask
  task automatic send(input logic [6:0] w, input logic bad);
    mp = mp ^ w;
    word(w, bad);
  endtask
  task automatic frame(input logic [6:0] ctl, input int bad);
    mp = 7'h7F;
    word(7'h16, 1'b0);
    word(7'h16, 1'b0);
    send(7'h01, 1'b0);
    send(7'h71, 1'b0);
    send(7'h60, 1'b0);
    send(ctl, 1'b0);
    if (ctl == 7'h0C || ctl == 7'h12)
      repeat (7) word(7'h16, 1'b0);
    foreach (dat[i])
    begin
      send(dat[i], i == bad);
      // Gap lets the slow buffer chain keep up with the fast bench link
      #20000;
    end
    send(7'h03, 1'b0);
    word(mp, 1'b0);
    dat.delete();
    rxData = ~rxData;
  endtask
endmodule

// ===== test_remote_terminal_message_receiver.sv
// Self-checking bench for the remote terminal message receiver
`timescale 1ns/1ps
module test_remote_terminal_message_receiver
  import rtm_pkg::*;
;
  logic        mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rxClk, rxData, sendKey, siteBusy, entryHit, alertOn;
  rtm_mem_t    memPort;
  rtm_reply_t  replyPort;
  rtm_func_t   funcPort;
  logic [6:0]  lastCode, w, memQ[$], expQ[$];
  int          fails, checked, replies, clears, cycles, n;
  assign hready = hreadyout;
  rtm_receiver i_dut (.mclk(mclk), .reset_n(reset_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .rxClk(rxClk), .rxData(rxData),
    .sendKey(sendKey), .siteBusy(siteBusy), .entryHit(entryHit),
    .memPort(memPort), .replyPort(replyPort), .funcPort(funcPort),
    .alertOn(alertOn));
  rtm_source i_src (.rxClk(rxClk), .rxData(rxData));
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic complete_run;
    if (fails == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      fails++;
      complete_run();
    end
    if (replyPort.valid === 1'b1)
    begin
      lastCode = replyPort.code;
      replies++;
    end
    if (memPort.write === 1'b1)
      memQ.push_back(memPort.data);
    if (memPort.clear === 1'b1)
      clears++;
    // Random marker hits make the chain stall and stack words up
    if (reset_n)
      entryHit <= ($urandom % 4) == 0;
  end
  task automatic ahb(input logic wr, input logic [31:0] a, d);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_reply(input int n0, input logic [6:0] code);
    for (int i = 0; i < 400 && replies == n0; i++)
      @(posedge mclk);
    check("reply", 32'(lastCode), 32'(code));
  endtask
  task automatic msg(input logic [6:0] ctl, input int bad, code);
    int n0;
    n0 = replies;
    i_src.frame(ctl, bad);
    wait_reply(n0, code[6:0]);
  endtask
  initial
  begin
    {reset_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {sendKey, siteBusy, entryHit} = '0;
    hsize = 3'h2;
    void'($urandom(85768));
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    ahb(1'b1, 32'h0, 32'h0);
    msg(7'h05, -1, 7'h18);
    ahb(1'b1, 32'h0, 32'h2);
    msg(7'h05, -1, 7'h06);
    ahb(1'b0, 32'h4, 32'h0);
    check("wait", 32'(rd[0]), 32'h1);
    n = replies;
    sendKey <= 1'b1;
    @(posedge mclk);
    sendKey <= 1'b0;
    wait_reply(n, 7'h13);
    ahb(1'b1, 32'h0, 32'hC);
    for (int k = 0; k < 2; k++)
    begin
      memQ.delete();
      expQ.delete();
      clears = 0;
      for (int j = 0; j < 6; j++)
      begin
        w = j == 0 ? 7'h00 : j == 1 ? 7'h10 : 7'($urandom % 64);
        if (w == 7'h03 || w == 7'h16 || w == 7'h3E)
          w = 7'h05;
        i_src.dat.push_back(w);
        // External code set swaps 00 and 20
        expQ.push_back(k == 1 && j == 2 ? 7'h3E : w == 0 ? 7'h10
          : w == 7'h10 ? 7'h00 : w);
      end
      msg(k ? 7'h11 : 7'h12, k ? 2 : -1, k ? 7'h15 : 7'h06);
      for (int i = 0; i < 3000 && memQ.size() < 6; i++)
        @(posedge mclk);
      check("count", memQ.size(), 6);
      foreach (expQ[i]) check("mem", 32'(memQ[i]), 32'(expQ[i]));
      check("clear", clears, 32'(k == 0));
    end
    ahb(1'b0, 32'h0C, 32'h0);
    check("unmapped", rd, 32'h0);
    ahb(1'b1, 32'h0, 32'h1);
    msg(7'h07, -1, 7'h06);
    check("lamp", 32'(alertOn), 32'h1);
    sendKey <= 1'b1;
    @(posedge mclk);
    sendKey <= 1'b0;
    for (int i = 0; i < 50 && alertOn; i++)
      @(posedge mclk);
    check("lamp off", 32'(alertOn), 32'h0);
    siteBusy <= 1'b1;
    msg(7'h11, -1, 7'h18);
    ahb(1'b1, 32'h0, 32'h0);
    msg(7'h07, -1, 7'h06);
    msg(7'h05, -1, 7'h13);
    ahb(1'b0, 32'h8, 32'h0);
    check("one word", rd, 32'h93);
    complete_run();
  end
endmodule
